// file: core/pll_cfg_params.svh
// offsets, field positions, reset values and thresholds of the pll config slice
// assumes word-indexed registers, byte address is four times the index
`ifndef PLL_CFG_PARAMS_SVH
`define PLL_CFG_PARAMS_SVH
`define IDX_REFDIV 6'h03
`define IDX_AUXWR 6'h05
`define IDX_TRIG 6'h0A
`define IDX_PD 6'h0B
`define IDX_EXACT 6'h0C
`define TRIG_NO_AUX 12
`define TRIG_BYPASS 16
`define PD_DELAY_HI 2
`define PD_SHORT 3
`define PD_FLIP 4
`define DET_UP_ENABLE 5
`define DET_DN_ENABLE 6
`define PD_CSP_HI 8
`define PD_CSP_LO 7
`define PD_FORCE_UP 9
`define PD_FORCE_DN 10
`define PD_MID_RAIL 11
`define PD_PSB_HI 14
`define PD_PSB_LO 12
`define PD_GATE_HI 18
`define PD_GATE_LO 17
`define PD_PW_HI 21
`define PD_PW_LO 20
`define RST_TRIG 17'h00000
`define RST_PD 24'hF8061
`define RST_EXACT 14'h0000
`define RST_REFDIV 14'h0001
`define RST_AUXWR 24'h000000
`define BYPASS_RATIO 14'h0001
`define CSP_THR1_NS 8'h02
`define CSP_THR2_NS 8'h04
`define CSP_THR3_NS 8'h06
`define GATE_LIM0 19'h00020
`define GATE_LIM1 19'h00080
`define GATE_LIM2 19'h003FF
`define EXACT_MIN 14'h0002
`endif

// file: core/pll_cfg_pkg.sv
// types shared by the pll config slice
// assumes nothing beyond the params header
package pll_cfg_pkg;
  typedef enum logic {APB_IDLE, APB_ANSWER} apb_state_t;
  typedef logic [1:0] mode2_t;
endpackage

// file: core/pll_cfg_if.sv
// control fields passed from the register bank to its helpers
// assumes one clock domain
`timescale 1ns/1ps
interface pll_cfg_if;
  logic polarity_flip;
  logic up_en;
  logic dn_en;
  logic force_up;
  logic force_dn;
  logic mid_rail;
  pll_cfg_pkg::mode2_t cycle_slip_guard_mode;
  pll_cfg_pkg::mode2_t gate_mode;
  logic [13:0] exact_count;
  modport cfg (output polarity_flip, up_en, dn_en, force_up, force_dn, mid_rail,
    cycle_slip_guard_mode, gate_mode, exact_count);
  modport use_side (input polarity_flip, up_en, dn_en, force_up, force_dn, mid_rail,
    cycle_slip_guard_mode, gate_mode, exact_count);
endinterface

// file: core/detector_steer.sv
// phase detector steering: polarity, gating, test forces, cycle slip boost
// assumes raw detector pulses and phase error in ns synchronous to ref_clk
`timescale 1ns/1ps
`include "pll_cfg_params.svh"
module detector_steer (
  input wire logic ref_clk,
  input wire logic rst_n,
  pll_cfg_if.use_side c,
  input wire logic pd_up_raw,
  input wire logic pd_dn_raw,
  input wire logic [7:0] phase_error_ns,
  output logic cp_up_ff,
  output logic cp_dn_ff,
  output logic cp_mid_rail_ff,
  output logic cp_gain_boost_ff
);
  function automatic logic [7:0] csp_limit(input pll_cfg_pkg::mode2_t m);
    case (m)
      2'h1: csp_limit = `CSP_THR1_NS;
      2'h2: csp_limit = `CSP_THR2_NS;
      default: csp_limit = `CSP_THR3_NS;
    endcase
  endfunction
  wire up_sw = c.polarity_flip ? pd_dn_raw : pd_up_raw;
  wire dn_sw = c.polarity_flip ? pd_up_raw : pd_dn_raw;
  wire nxt_up = c.force_up | (up_sw & c.up_en & ~c.mid_rail);
  wire nxt_dn = c.force_dn | (dn_sw & c.dn_en & ~c.mid_rail);
  wire guard_on = c.cycle_slip_guard_mode != 2'h0;
  wire nxt_boost = guard_on & (phase_error_ns > csp_limit(c.cycle_slip_guard_mode));
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cp_up_ff <= 1'b0;
      cp_dn_ff <= 1'b0;
      cp_mid_rail_ff <= 1'b0;
      cp_gain_boost_ff <= 1'b0;
    end
    else
    begin
      cp_up_ff <= nxt_up;
      cp_dn_ff <= nxt_dn;
      cp_mid_rail_ff <= c.mid_rail;
      cp_gain_boost_ff <= nxt_boost;
    end
  end
  a_csp_off_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    c.cycle_slip_guard_mode == 2'h0 |=> !cp_gain_boost_ff)
    else $error("boost with guard off");
  a_force_up_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    c.force_up |=> cp_up_ff)
    else $error("forced up not on");
endmodule

// file: core/divider_gate.sv
// main counter clock gate and exact frequency enable
// assumes the divide value is a static input on ref_clk
`timescale 1ns/1ps
`include "pll_cfg_params.svh"
module divider_gate (
  input wire logic ref_clk,
  input wire logic rst_n,
  pll_cfg_if.use_side c,
  input wire logic [18:0] n_divide,
  output logic main_counter_run_ff,
  output logic exact_freq_enable_ff
);
  function automatic logic [18:0] gate_limit(input pll_cfg_pkg::mode2_t m);
    case (m)
      2'h0: gate_limit = `GATE_LIM0;
      2'h1: gate_limit = `GATE_LIM1;
      default: gate_limit = `GATE_LIM2;
    endcase
  endfunction
  wire nxt_run = (c.gate_mode == 2'h3) | (n_divide >= gate_limit(c.gate_mode));
  wire nxt_exact = c.exact_count >= `EXACT_MIN;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      main_counter_run_ff <= 1'b1;
      exact_freq_enable_ff <= 1'b0;
    end
    else
    begin
      main_counter_run_ff <= nxt_run;
      exact_freq_enable_ff <= nxt_exact;
    end
  end
  a_gate_all_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    c.gate_mode == 2'h3 |=> main_counter_run_ff)
    else $error("gate stopped in mode 3");
  a_exact_low_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    c.exact_count < 14'h0002 |=> !exact_freq_enable_ff)
    else $error("exact on below 2");
endmodule

// file: core/pll_pd_exact_freq_cfg_regs.sv
// apb register bank for trigger/bypass, phase detector and exact frequency
// assumes an apb master on ref_clk; registers sit at byte address index*4
`timescale 1ns/1ps
`include "pll_cfg_params.svh"
module pll_pd_exact_freq_cfg_regs (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pd_up_raw,
  input wire logic pd_dn_raw,
  input wire logic [7:0] phase_error_ns,
  input wire logic [18:0] n_divide,
  output logic auxiliary_serial_port_start,
  output logic ref_divider_bypass,
  output logic [13:0] ref_divide_ratio,
  output logic [2:0] detector_reset_delay_select,
  output logic detector_inputs_short,
  output logic cp_up,
  output logic cp_dn,
  output logic cp_mid_rail,
  output logic cp_gain_boost,
  output logic [2:0] prescaler_bias_select,
  output logic main_counter_clock_gate,
  output logic [1:0] divider_pulse_width,
  output logic exact_freq_enable,
  output logic [13:0] exact_freq_channels
);
  pll_cfg_pkg::apb_state_t state_ff;
  pll_cfg_pkg::apb_state_t nxt_state;
  logic [16:0] trig_ff;
  logic [23:0] pd_ff;
  logic [13:0] exact_ff;
  logic [13:0] refdiv_ff;
  logic [23:0] auxwr_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic aux_start_ff;
  logic [13:0] ratio_ff;
  logic cp_up_w;
  logic cp_dn_w;
  logic cp_mid_w;
  logic cp_boost_w;
  logic run_w;
  logic exact_en_w;

  pll_cfg_if cfg_bus ();

  function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
    hit = (a[7:2] == idx) & (a[1:0] == 2'h0);
  endfunction

  wire access = psel & penable;
  wire hit_trig = hit(paddr, `IDX_TRIG);
  wire hit_pd = hit(paddr, `IDX_PD);
  wire hit_exact = hit(paddr, `IDX_EXACT);
  wire hit_refdiv = hit(paddr, `IDX_REFDIV);
  wire hit_auxwr = hit(paddr, `IDX_AUXWR);
  wire mapped = hit_trig | hit_pd | hit_exact | hit_refdiv | hit_auxwr;
  wire first_access = access & (state_ff == pll_cfg_pkg::APB_IDLE);
  wire commit = access & pwrite & pready_ff & ~pslverr_ff;
  wire wr_trig = commit & hit_trig;
  wire wr_pd = commit & hit_pd;
  wire wr_exact = commit & hit_exact;
  wire wr_refdiv = commit & hit_refdiv;
  wire wr_auxwr = commit & hit_auxwr;

  // every field reads back as stored, reserved bits included
  wire [31:0] rd_mux =
    hit_trig ? {15'h0000, trig_ff} :
    hit_pd ? {8'h00, pd_ff} :
    hit_exact ? {18'h00000, exact_ff} :
    hit_refdiv ? {18'h00000, refdiv_ff} :
    hit_auxwr ? {8'h00, auxwr_ff} :
    32'h00000000;

  wire nxt_aux_start = wr_auxwr & ~trig_ff[`TRIG_NO_AUX];
  wire bypass = trig_ff[`TRIG_BYPASS];
  wire [13:0] nxt_ratio = bypass ? `BYPASS_RATIO : refdiv_ff;

  always_comb
  begin
    case (state_ff)
      pll_cfg_pkg::APB_IDLE: nxt_state = access ? pll_cfg_pkg::APB_ANSWER
        : pll_cfg_pkg::APB_IDLE;
      pll_cfg_pkg::APB_ANSWER: nxt_state = pll_cfg_pkg::APB_IDLE;
      default: nxt_state = pll_cfg_pkg::APB_IDLE;
    endcase
  end

  // one wait state: pready rises on the second access cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_ff <= pll_cfg_pkg::APB_IDLE;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end
    else
    begin
      state_ff <= nxt_state;
      pready_ff <= first_access;
      if (first_access)
      begin
        pslverr_ff <= ~mapped;
        prdata_ff <= pwrite ? 32'h00000000 : rd_mux;
      end
      else
      begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      trig_ff <= `RST_TRIG;
      pd_ff <= `RST_PD;
      exact_ff <= `RST_EXACT;
      refdiv_ff <= `RST_REFDIV;
      auxwr_ff <= `RST_AUXWR;
    end
    else
    begin
      if (wr_trig)
        trig_ff <= pwdata[16:0];
      if (wr_pd)
        pd_ff <= pwdata[23:0];
      if (wr_exact)
        exact_ff <= pwdata[13:0];
      if (wr_refdiv)
        refdiv_ff <= pwdata[13:0];
      if (wr_auxwr)
        auxwr_ff <= pwdata[23:0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      aux_start_ff <= 1'b0;
      ratio_ff <= `RST_REFDIV;
    end
    else
    begin
      aux_start_ff <= nxt_aux_start;
      ratio_ff <= nxt_ratio;
    end
  end

  assign cfg_bus.polarity_flip = pd_ff[`PD_FLIP];
  assign cfg_bus.up_en = pd_ff[`DET_UP_ENABLE];
  assign cfg_bus.dn_en = pd_ff[`DET_DN_ENABLE];
  assign cfg_bus.force_up = pd_ff[`PD_FORCE_UP];
  assign cfg_bus.force_dn = pd_ff[`PD_FORCE_DN];
  assign cfg_bus.mid_rail = pd_ff[`PD_MID_RAIL];
  assign cfg_bus.cycle_slip_guard_mode = pd_ff[`PD_CSP_HI:`PD_CSP_LO];
  assign cfg_bus.gate_mode = pd_ff[`PD_GATE_HI:`PD_GATE_LO];
  assign cfg_bus.exact_count = exact_ff;

  detector_steer u_steer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .c(cfg_bus.use_side),
    .pd_up_raw(pd_up_raw),
    .pd_dn_raw(pd_dn_raw),
    .phase_error_ns(phase_error_ns),
    .cp_up_ff(cp_up_w),
    .cp_dn_ff(cp_dn_w),
    .cp_mid_rail_ff(cp_mid_w),
    .cp_gain_boost_ff(cp_boost_w)
  );

  divider_gate u_gate (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .c(cfg_bus.use_side),
    .n_divide(n_divide),
    .main_counter_run_ff(run_w),
    .exact_freq_enable_ff(exact_en_w)
  );

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign auxiliary_serial_port_start = aux_start_ff;
  assign ref_divider_bypass = trig_ff[`TRIG_BYPASS];
  assign ref_divide_ratio = ratio_ff;
  assign detector_reset_delay_select = pd_ff[`PD_DELAY_HI:0];
  assign detector_inputs_short = pd_ff[`PD_SHORT];
  assign cp_up = cp_up_w;
  assign cp_dn = cp_dn_w;
  assign cp_mid_rail = cp_mid_w;
  assign cp_gain_boost = cp_boost_w;
  assign prescaler_bias_select = pd_ff[`PD_PSB_HI:`PD_PSB_LO];
  assign main_counter_clock_gate = run_w;
  assign divider_pulse_width = pd_ff[`PD_PW_HI:`PD_PW_LO];
  assign exact_freq_enable = exact_en_w;
  assign exact_freq_channels = exact_ff;

  a_aux_start_ok: assert property (@(posedge ref_clk) disable iff (!rst_n)
    commit && hit_auxwr && !trig_ff[12] |=> auxiliary_serial_port_start)
    else $error("aux transfer not started");
  a_aux_start_blocked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    auxiliary_serial_port_start |-> $past(trig_ff[12]) == 1'b0 && $past(commit))
    else $error("aux start while suppressed");
  a_bypass_ratio: assert property (@(posedge ref_clk) disable iff (!rst_n)
    trig_ff[16] |=> ref_divide_ratio == 14'h0001)
    else $error("divider not bypassed");
  a_pd_reset_val: assert property (@(posedge ref_clk)
    !rst_n |=> pd_ff == 24'hF8061 && detector_reset_delay_select == 3'h1)
    else $error("pd register reset value wrong");
  a_short_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_pd |=> detector_inputs_short == $past(pwdata[3]))
    else $error("short bit not written");
  a_polarity_swap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pd_ff[4] && pd_ff[6] && !pd_ff[10] && !pd_ff[11] && pd_up_raw |=> cp_dn)
    else $error("swapped down missing");
  a_up_gate_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pd_ff[5] && !pd_ff[9] |=> !cp_up)
    else $error("up output not gated");
  a_csp_thresh: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pd_ff[8:7] == 2'h2 && phase_error_ns == 8'h05 |=> cp_gain_boost)
    else $error("boost missed above 4 ns");
  a_mid_rail: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pd_ff[11] && !pd_ff[9] |=> cp_mid_rail && !cp_up)
    else $error("mid rail not held");
  a_gate_below: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pd_ff[18:17] == 2'h1 && n_divide == 19'h0007F |=> !main_counter_clock_gate)
    else $error("counter ran below 128");
  a_exact_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exact_ff == 14'h0002 |=> exact_freq_enable)
    else $error("exact mode off at 2");
  a_apb_one_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
    psel && !penable ##1 psel && penable |-> !pready ##1 pready)
    else $error("apb answer timing");

  // bus answer shape: one pulse, error only with it, data zero where nothing is read
  a_ready_one_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pready |=> !pready)
    else $error("apb ready longer than one cycle");
  a_ready_after_access: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pready |-> $past(psel && penable))
    else $error("apb ready without access");
  a_err_with_ready: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pslverr |-> pready)
    else $error("apb error without ready");
  a_unmapped_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
    first_access && !mapped |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  a_mapped_no_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
    first_access && mapped |=> !pslverr)
    else $error("mapped access refused");
  a_write_rdata_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    first_access && pwrite |=> prdata == 32'h00000000)
    else $error("read data not zero on write");
  a_read_trig_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
    first_access && !pwrite && hit_trig |=> prdata == {15'h0000, $past(trig_ff)})
    else $error("trigger read back wrong");
  a_read_pd_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
    first_access && !pwrite && hit_pd |=> prdata == {8'h00, $past(pd_ff)})
    else $error("detector read back wrong");
  a_read_exact_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
    first_access && !pwrite && hit_exact |=> prdata == {18'h00000, $past(exact_ff)})
    else $error("exact read back wrong");

  // stored values follow the committed write word and nothing else
  a_trig_stored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_trig |=> trig_ff == $past(pwdata[16:0]))
    else $error("trigger write lost");
  a_pd_stored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_pd |=> pd_ff == $past(pwdata[23:0]))
    else $error("detector write lost");
  a_exact_stored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_exact |=> exact_freq_channels == $past(pwdata[13:0]))
    else $error("exact write lost");
  a_refdiv_stored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_refdiv |=> refdiv_ff == $past(pwdata[13:0]))
    else $error("divider write lost");
  a_auxwr_stored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_auxwr |=> auxwr_ff == $past(pwdata[23:0]))
    else $error("aux write lost");
  a_err_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    access && pslverr_ff |=> $stable(trig_ff) && $stable(pd_ff) && $stable(exact_ff)
    && $stable(refdiv_ff) && $stable(auxwr_ff))
    else $error("refused access wrote a register");
  a_idle_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !commit |=> $stable(trig_ff) && $stable(pd_ff) && $stable(exact_ff))
    else $error("register changed without a write");

  // behaviour of the fields at the block outputs
  a_aux_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    auxiliary_serial_port_start |=> !auxiliary_serial_port_start)
    else $error("aux start longer than one cycle");
  a_aux_no_trigger: assert property (@(posedge ref_clk) disable iff (!rst_n)
    commit && hit_auxwr && trig_ff[`TRIG_NO_AUX] |=> !auxiliary_serial_port_start)
    else $error("aux transfer started while blocked");
  a_ratio_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !trig_ff[`TRIG_BYPASS] |=> ref_divide_ratio == $past(refdiv_ff))
    else $error("ratio not taken from divider register");
  a_delay_stored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_pd |=> detector_reset_delay_select == $past(pwdata[2:0]))
    else $error("delay select not written");
  a_polarity_plain: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pd_ff[4] && pd_ff[5] && !pd_ff[11] && pd_up_raw |=> cp_up)
    else $error("plain up missing");
  a_up_from_down: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pd_ff[4] && pd_ff[5] && !pd_ff[11] && pd_dn_raw |=> cp_up)
    else $error("swapped up missing");
  a_dn_gate_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pd_ff[6] && !pd_ff[10] |=> !cp_dn)
    else $error("down output not gated");
  a_force_dn_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pd_ff[10] |=> cp_dn)
    else $error("forced down not on");
  a_mid_rail_dn: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pd_ff[11] && !pd_ff[10] |=> !cp_dn)
    else $error("down pulse during mid rail");
  a_csp_at_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pd_ff[8:7] == 2'h1 && phase_error_ns == 8'h02 |=> !cp_gain_boost)
    else $error("boost at exactly 2 ns");
  a_csp_above_six: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pd_ff[8:7] == 2'h3 && phase_error_ns == 8'h07 |=> cp_gain_boost)
    else $error("boost missed above 6 ns");
  a_bias_stored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_pd |=> prescaler_bias_select == $past(pwdata[14:12]))
    else $error("prescaler bias not written");
  a_width_stored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_pd |=> divider_pulse_width == $past(pwdata[21:20]))
    else $error("pulse width not written");
  a_gate_at_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pd_ff[18:17] == 2'h2 && n_divide == 19'h003FF |=> main_counter_clock_gate)
    else $error("counter stopped at 1023");
  a_exact_off_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exact_ff == 14'h0001 |=> !exact_freq_enable)
    else $error("exact mode on at 1");
endmodule

// file: verification/apb_host_model.sv
// host side model: apb master that issues one transfer at a time
// assumes a slave that raises pready in its own time; the bench watchdog ends a hang
`timescale 1ns/1ps
module apb_host_model (
  input wire logic ref_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // whole words only; reserved bits go out as given by the caller
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
      begin
        @(posedge ref_clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
endmodule

// file: verification/pll_pd_exact_freq_cfg_regs_tb.sv
// self-checking bench for the pll config register slice
// assumes the apb host model and the design files are compiled first
`timescale 1ns/1ps
module pll_pd_exact_freq_cfg_regs_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, up_raw = 1'b0, dn_raw = 1'b0;
  logic [7:0] paddr;
  logic [7:0] perr = 8'h00;
  logic [31:0] pwdata, prdata, rd;
  logic [18:0] ndiv = 19'h00000;
  logic aux_go, byp, d_short, cp_up, cp_dn, cp_mid, boost, gate, ex_en, er;
  logic [13:0] ratio, ex_cnt;
  logic [2:0] dly, psb;
  logic [1:0] pw;
  int err_total = 0;
  int num_checks = 0;
  int pulses = 0;
  int model [0:63];
  int lim [0:2] = '{32, 128, 1023};
  int v, p, e;
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (aux_go === 1'b1)
      pulses++;
  apb_host_model host_i (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));
  pll_pd_exact_freq_cfg_regs pll_pd_exact_freq_cfg_regs_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pd_up_raw(up_raw),
    .pd_dn_raw(dn_raw), .phase_error_ns(perr), .n_divide(ndiv),
    .auxiliary_serial_port_start(aux_go), .ref_divider_bypass(byp), .ref_divide_ratio(ratio),
    .detector_reset_delay_select(dly), .detector_inputs_short(d_short), .cp_up(cp_up),
    .cp_dn(cp_dn), .cp_mid_rail(cp_mid), .cp_gain_boost(boost),
    .prescaler_bias_select(psb), .main_counter_clock_gate(gate),
    .divider_pulse_width(pw), .exact_freq_enable(ex_en), .exact_freq_channels(ex_cnt));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  function automatic int wmask(input int idx);
    return idx == 3 || idx == 12 ? 32'h3FFF : idx == 10 ? 32'h1FFFF : 32'hFFFFFF;
  endfunction
  task automatic wr(input int idx, input int d);
    host_i.xfer(1'b1, 8'(idx * 4), d, rd, er);
    chk("write error", er, 0);
    model[idx] = d & wmask(idx);
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic rdchk(input int idx);
    host_i.xfer(1'b0, 8'(idx * 4), 0, rd, er);
    chk("readback", rd, model[idx]);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    report_and_stop;
  end
  initial
  begin
    void'($urandom(34167));
    model = '{default: 0};
    model[3] = 1;
    model[11] = 32'hF8061;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (model[i])
      if (i inside {3, 5, 10, 11, 12})
        rdchk(i);
    chk("delay", dly, 1);
    chk("gate", gate, 1);
    chk("pulse width", pw, 0);
    host_i.xfer(1'b0, 8'h40, 0, rd, er);
    chk("unmapped err", er, 1);
    chk("unmapped data", rd, 0);
    host_i.xfer(1'b1, 8'h2D, 32'h00FFFFFF, rd, er);
    chk("misaligned err", er, 1);
    rdchk(11);
    $display("test reset done");
    for (int t = 0; t < 2; t++)
    begin
      wr(10, t << 12);
      p = pulses;
      wr(5, $urandom);
      chk("aux start", pulses - p, 1 - t);
      v = $urandom & 32'h3FFF;
      wr(3, v);
      wr(10, t << 16);
      chk("ratio", {byp, ratio}, t ? 32'h4001 : v);
    end
    $display("test aux and bypass done");
    for (int k = 0; k < 8; k++)
    begin
      wr(11, $urandom);
      rdchk(11);
      chk("fields", {d_short, dly, psb, pw}, {model[11][3], model[11][2:0],
        model[11][14:12], model[11][21:20]});
    end
    $display("test field map done");
    for (int k = 0; k < 64; k++)
    begin
      v = $urandom & 32'hE70;
      wr(11, 32'hF8001 | v);
      up_raw <= 1'($urandom);
      dn_raw <= 1'($urandom);
      repeat (3) @(posedge ref_clk);
      p = v[4] ? dn_raw : up_raw;
      e = v[4] ? up_raw : dn_raw;
      chk("pump up", cp_up, v[9] | (!v[11] & v[5] & p));
      chk("pump dn", cp_dn, v[10] | (!v[11] & v[6] & e));
      chk("mid rail", cp_mid, v[11]);
    end
    $display("test steering done");
    for (int m = 0; m < 4; m++)
    begin
      wr(11, 32'hF8061 | (m << 7));
      foreach (lim[j])
      begin
        perr <= 8'(2 * m + j);
        repeat (3) @(posedge ref_clk);
        chk("boost", boost, m != 0 && 2 * m + j > 2 * m);
      end
      wr(11, 32'h98061 | (m << 17));
      for (int j = 0; j < 2; j++)
      begin
        p = m == 3 ? $urandom & 32'h7FFFF : lim[m] - 1 + j;
        ndiv <= 19'(p);
        repeat (3) @(posedge ref_clk);
        chk("gate", gate, m == 3 || p >= lim[m]);
      end
    end
    $display("test boost and gate done");
    // counts below assume modulator mode b and an integer channel ratio
    foreach (lim[j])
    begin
      v = j == 0 ? 1 : j == 1 ? 2 : $urandom & 32'h3FFF;
      wr(12, v);
      rdchk(12);
      chk("exact enable", {ex_en, ex_cnt}, {v >= 2, v[13:0]});
    end
    wr(12, 32'h3FFF);
    chk("exact max", {ex_en, ex_cnt}, 15'h7FFF);
    wr(12, 0);
    $display("test exact done");
    report_and_stop;
  end
endmodule
